/* verilog/link_slot_capability_registers.sv */
// Operation
// - Link control bits 1:0 hold a read-write power management field resetting to 00.
// - Link control bit 3 reads zero and ignores writes.
// - Link disable and retrain bits are writable only in reverse direction, reset 0.
// - Link status bits 19:16 report negotiated speed, resetting to 1.
// - Link status bits 25:20 report negotiated width, resetting to x1.
// - Slot capability bits 0,2,3,4,6 read one only with hot-plug on in reverse direction.
// - Those capability bits follow the hot-plug strap, sampled every cycle.
`timescale 1ns/1ps
`default_nettype none
module link_slot_capability_registers (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Straps and mode pins
  input wire logic hp_strap,
  input wire logic reverse_dir,
  // Link state from training logic
  input wire logic [3:0] link_speed,
  input wire logic [5:0] link_width,
  input wire logic link_train_err,
  input wire logic link_training,
  // Slot events and states from hot-plug logic
  input wire logic [4:0] slot_evt,
  input wire logic mrl_state,
  input wire logic presence_state,
  // Controls out
  output logic [1:0] aspm_ctrl,
  output logic link_disable,
  output logic retrain_link,
  output logic [10:0] slot_ctrl,
  // Interrupt
  output logic irq
);
  // =====================================================
  // Pin synchronisers
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [15:0] pin_raw;
  assign pin_raw = {presence_state, mrl_state, slot_evt, link_training, link_train_err,
                    link_width, reverse_dir};
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // Width lanes reset to x1 so a read straight after reset shows it
      sync1_q <= {9'h000, slot_regs_pkg::width_rst, 1'b0};
      sync2_q <= {9'h000, slot_regs_pkg::width_rst, 1'b0};
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic rev_s;
  logic [5:0] width_s;
  logic err_s;
  logic trn_s;
  logic [4:0] evt_s;
  logic mrl_s;
  logic pres_s;
  assign rev_s = sync2_q[0];
  assign width_s = sync2_q[6:1];
  assign err_s = sync2_q[7];
  assign trn_s = sync2_q[8];
  assign evt_s = sync2_q[13:9];
  assign mrl_s = sync2_q[14];
  assign pres_s = sync2_q[15];
  logic [3:0] spd1_q;
  logic [3:0] spd2_q;
  logic strap1_q;
  logic strap2_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      spd1_q <= slot_regs_pkg::speed_rst;
      spd2_q <= slot_regs_pkg::speed_rst;
      strap1_q <= 1'b0;
      strap2_q <= 1'b0;
    end
    else
    begin
      spd1_q <= link_speed;
      spd2_q <= spd1_q;
      strap1_q <= hp_strap;
      strap2_q <= strap1_q;
    end
  end
  // =====================================================
  // Address decode
  logic hit_link;
  logic hit_cap;
  logic hit_slot;
  logic hit_ist;
  logic hit_imask;
  assign hit_link = addr == slot_regs_pkg::link_ctrl_off;
  assign hit_cap = addr == slot_regs_pkg::slot_cap_off;
  assign hit_slot = addr == slot_regs_pkg::slot_ctrl_off;
  assign hit_ist = addr == slot_regs_pkg::irq_status_off;
  assign hit_imask = addr == slot_regs_pkg::irq_mask_off;
  // =====================================================
  // Link control
  logic [1:0] aspm_q;
  logic dis_q;
  logic retr_q;
  logic cclk_q;
  logic xsync_q;
  logic wr_link;
  logic wr_rev;
  assign wr_link = wr && hit_link;
  assign wr_rev = wr_link && rev_s;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aspm_q <= slot_regs_pkg::aspm_rst;
      dis_q <= 1'b0;
      retr_q <= 1'b0;
      cclk_q <= 1'b0;
      xsync_q <= 1'b0;
    end
    else
    begin
      if (wr_link)
      begin
        aspm_q <= wdata[slot_regs_pkg::aspm_lo +: 2];
        cclk_q <= wdata[slot_regs_pkg::common_clk_bit];
        xsync_q <= wdata[slot_regs_pkg::ext_sync_bit];
      end
      if (wr_rev)
      begin
        dis_q <= wdata[slot_regs_pkg::link_dis_bit];
        retr_q <= wdata[slot_regs_pkg::retrain_bit];
      end
    end
  end
  assign aspm_ctrl = aspm_q;
  assign link_disable = dis_q;
  assign retrain_link = retr_q;
  // =====================================================
  // Slot control
  logic [10:0] sctl_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sctl_q <= slot_regs_pkg::slot_ctrl_rst;
    else if (wr && hit_slot)
      sctl_q <= wdata[10:0];
  end
  assign slot_ctrl = sctl_q;
  // =====================================================
  // Slot capability: strap sampled every cycle through two flops
  // Combinational on synced pins: a strap or direction change shows two cycles later
  logic hp_en;
  assign hp_en = strap2_q && rev_s;
  logic [31:0] cap_word;
  assign cap_word = hp_en ? slot_regs_pkg::hp_cap_mask : 32'h00000000;
  // =====================================================
  // Interrupt status and mask
  logic [4:0] evt_d1_q;
  logic [4:0] ist_q;
  logic [4:0] imask_q;
  logic [4:0] evt_rise;
  assign evt_rise = evt_s & ~evt_d1_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      evt_d1_q <= 5'h00;
      ist_q <= slot_regs_pkg::irq_rst;
      imask_q <= slot_regs_pkg::irq_rst;
    end
    else
    begin
      evt_d1_q <= evt_s;
      // Set wins over a same-cycle clear
      ist_q <= (ist_q & ~((wr && hit_ist) ? wdata[4:0] : 5'h00)) | evt_rise;
      if (wr && hit_imask)
        imask_q <= wdata[4:0];
    end
  end
  assign irq = |(ist_q & imask_q);
  // =====================================================
  // Read mux
  logic [31:0] link_word;
  logic [31:0] slot_word;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  assign link_word = {3'h0, 1'b1, trn_s, err_s, width_s, spd2_q,
                      8'h00, xsync_q, cclk_q, retr_q, dis_q, 1'b0, 1'b0, aspm_q};
  assign slot_word = {9'h000, pres_s, mrl_s, evt_s, 5'h00, sctl_q};
  assign rd_d = hit_link ? link_word :
                hit_cap ? cap_word :
                hit_slot ? slot_word :
                hit_ist ? {27'h0, ist_q} :
                hit_imask ? {27'h0, imask_q} : 32'h00000000;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (rd)
      rdata_q <= rd_d;
    else
      rdata_q <= 32'h00000000;
  end
  assign rdata = rdata_q;
  // =====================================================
  // Checks
  aspm_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_link |=> aspm_ctrl == $past(wdata[1:0])
  )
  else $error("aspm not stored");
  aspm_reset_a: assert property (
    @(posedge core_clk)
    $fell(rst) |-> aspm_ctrl == slot_regs_pkg::aspm_rst && !link_disable && !retrain_link
  )
  else $error("link control not reset");
  rcb_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd && hit_link |=> rdata[3] == 1'b0
  )
  else $error("rcb not zero");
  fwd_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_link && !rev_s |=> $stable(link_disable) && $stable(retrain_link)
  )
  else $error("link bits written in forward");
  rev_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_rev |=> link_disable == $past(wdata[4]) && retrain_link == $past(wdata[5])
  )
  else $error("link disable lost");
  speed_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd && hit_link |=> rdata[19:16] == $past(spd2_q)
  )
  else $error("speed wrong");
  width_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd && hit_link |=> rdata[25:20] == $past(width_s)
  )
  else $error("width wrong");
  // Readbacks straight after reset must already show the reset codes
  status_reset_a: assert property (
    @(posedge core_clk)
    $fell(rst) |-> width_s == slot_regs_pkg::width_rst && spd2_q == slot_regs_pkg::speed_rst
  )
  else $error("link status not reset");
  cap_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd && hit_cap |=> rdata == ($past(hp_en) ? slot_regs_pkg::hp_cap_mask : 32'h00000000)
  )
  else $error("capability wrong");
  strap_cap_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !strap2_q |-> cap_word == 32'h00000000
  )
  else $error("cap without strap");
  sctl_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr && hit_slot |=> slot_ctrl == $past(wdata[10:0])
  )
  else $error("slot ctrl lost");
  slot_ro_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd && hit_slot |=> rdata[22:16] == $past({pres_s, mrl_s, evt_s}) && rdata[15:11] == 5'h00
  )
  else $error("slot status wrong");
  irq_level_a: assert property (
    @(posedge core_clk) disable iff (rst)
    irq == |(ist_q & imask_q)
  )
  else $error("irq mismatch");
  // A rising event must land even when software clears in the same cycle
  ist_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    |evt_rise |=> (ist_q & $past(evt_rise)) == $past(evt_rise)
  )
  else $error("status event lost");
  rdata_idle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !rd |=> rdata == 32'h00000000
  )
  else $error("read data not idle");
  // Main scenarios
  rev_write_c: cover property (
    @(posedge core_clk) disable iff (rst) wr_rev);
  fwd_block_c: cover property (
    @(posedge core_clk) disable iff (rst) wr_link && !rev_s);
  hp_cap_c: cover property (
    @(posedge core_clk) disable iff (rst) rd && hit_cap && hp_en);
  irq_c: cover property (
    @(posedge core_clk) disable iff (rst) irq);
endmodule : link_slot_capability_registers
`default_nettype wire

/* verilog/slot_regs_pkg.sv */
`default_nettype none
package slot_regs_pkg;
  // =====================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] link_ctrl_off = 8'hc0;
  localparam logic [7:0] slot_cap_off = 8'hc4;
  localparam logic [7:0] slot_ctrl_off = 8'hc8;
  localparam logic [7:0] irq_status_off = 8'he8;
  localparam logic [7:0] irq_mask_off = 8'hec;
  // =====================================================
  // Field positions
  localparam int aspm_lo = 0;
  localparam int rcb_bit = 3;
  localparam int link_dis_bit = 4;
  localparam int retrain_bit = 5;
  localparam int common_clk_bit = 6;
  localparam int ext_sync_bit = 7;
  localparam int speed_lo = 16;
  localparam int width_lo = 20;
  localparam int train_err_bit = 26;
  localparam int training_bit = 27;
  localparam int slot_clk_bit = 28;
  localparam int slot_evt_lo = 16;
  localparam int slot_state_lo = 21;
  // =====================================================
  // Reset values
  localparam logic [1:0] aspm_rst = 2'h0;
  localparam logic [3:0] speed_rst = 4'h1;
  localparam logic [5:0] width_rst = 6'h01;
  localparam logic [10:0] slot_ctrl_rst = 11'h000;
  localparam logic [31:0] hp_cap_mask = 32'h0000005d;
  localparam logic [4:0] irq_rst = 5'h00;
endpackage : slot_regs_pkg
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========
  // Bench signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hp_strap = 1'b1;
  logic reverse_dir = 1'b0;
  logic [3:0] link_speed = 4'h1;
  logic [5:0] link_width = 6'h01;
  logic link_train_err = 1'b0;
  logic link_training = 1'b0;
  logic [4:0] slot_evt = 5'h00;
  logic mrl_state = 1'b0;
  logic presence_state = 1'b0;
  logic [31:0] rdata;
  logic [1:0] aspm_ctrl;
  logic link_disable;
  logic retrain_link;
  logic [10:0] slot_ctrl;
  logic irq;
  logic [5:0] widths [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
  int n_mismatch = 0;
  int n_tests = 0;
  always #25 core_clk = ~core_clk;
  link_slot_capability_registers i_link_slot_capability_registers (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hp_strap(hp_strap), .reverse_dir(reverse_dir),
    .link_speed(link_speed), .link_width(link_width), .link_train_err(link_train_err),
    .link_training(link_training), .slot_evt(slot_evt), .mrl_state(mrl_state),
    .presence_state(presence_state), .aspm_ctrl(aspm_ctrl), .link_disable(link_disable),
    .retrain_link(retrain_link), .slot_ctrl(slot_ctrl), .irq(irq));
  // ==========
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge core_clk);
  endtask : rd_chk
  // Pins pass a two-stage synchroniser
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask : settle
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // ==========
  // Tests
  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    rd_chk(slot_regs_pkg::link_ctrl_off, 32'h10110000);
    rd_chk(slot_regs_pkg::slot_cap_off, 32'h0);
    rd_chk(slot_regs_pkg::slot_ctrl_off, 32'h0);
    rd_chk(8'h10, 32'h0);
    for (int v = 0; v < 4; v++)
    begin
      wr_reg(slot_regs_pkg::link_ctrl_off, 32'hfffffffc | v);
      chk({28'h0, link_disable, retrain_link, aspm_ctrl}, v);
      rd_chk(slot_regs_pkg::link_ctrl_off, 32'h101100c0 | v);
    end
    reverse_dir <= 1'b1;
    settle();
    rd_chk(slot_regs_pkg::slot_cap_off, 32'h5d);
    wr_reg(slot_regs_pkg::link_ctrl_off, 32'h38);
    chk({28'h0, link_disable, retrain_link, aspm_ctrl}, 32'hc);
    rd_chk(slot_regs_pkg::link_ctrl_off, 32'h10110030);
    for (int i = 0; i < 7; i++)
    begin
      link_width <= widths[i];
      settle();
      rd_chk(slot_regs_pkg::link_ctrl_off, 32'h10010030 | {6'h0, widths[i], 20'h0});
    end
    link_width <= 6'h01;
    link_train_err <= 1'b1;
    link_training <= 1'b1;
    settle();
    rd_chk(slot_regs_pkg::link_ctrl_off, 32'h1c110030);
    wr_reg(slot_regs_pkg::slot_ctrl_off, 32'hffffffff);
    chk({21'h0, slot_ctrl}, 32'h7ff);
    mrl_state <= 1'b1;
    presence_state <= 1'b1;
    settle();
    rd_chk(slot_regs_pkg::slot_ctrl_off, 32'h006007ff);
    wr_reg(slot_regs_pkg::irq_mask_off, 32'h1);
    slot_evt <= 5'h01;
    settle();
    chk({31'h0, irq}, 32'h1);
    rd_chk(slot_regs_pkg::irq_status_off, 32'h1);
    rd_chk(slot_regs_pkg::slot_ctrl_off, 32'h006107ff);
    slot_evt <= 5'h02;
    settle();
    wr_reg(slot_regs_pkg::irq_status_off, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd_chk(slot_regs_pkg::irq_status_off, 32'h2);
    rd_chk(slot_regs_pkg::irq_mask_off, 32'h1);
    // Strap off must clear capability even in reverse mode
    hp_strap <= 1'b0;
    slot_evt <= 5'h00;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    rd_chk(slot_regs_pkg::slot_cap_off, 32'h0);
    rd_chk(slot_regs_pkg::slot_ctrl_off, 32'h00600000);
    chk({17'h0, slot_ctrl, link_disable, retrain_link, aspm_ctrl}, 32'h0);
    conclude();
  end
endmodule : tb
`default_nettype wire
